// ---- lsf_input_fifo.sv ----
// receive side of the four-bus sample interface with per-bus fifos
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module lsf_input_fifo #(
  parameter int READ_TICK = lsf_pkg::READ_TICK_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        bus_a_clock,
  input  wire logic                        bus_b_clock,
  input  wire logic                        bus_c_clock,
  input  wire logic                        bus_d_clock,
  input  wire logic [lsf_pkg::BUS_W-1:0]   bus_a_data,
  input  wire logic [lsf_pkg::BUS_W-1:0]   bus_b_data,
  input  wire logic [lsf_pkg::BUS_W-1:0]   bus_c_data,
  input  wire logic [lsf_pkg::BUS_W-1:0]   bus_d_data,
  input  wire logic                        bus_a_strobe,
  input  wire logic                        bus_b_strobe,
  input  wire logic                        bus_c_strobe,
  input  wire logic                        bus_d_strobe,
  input  wire logic                        sync_n,
  input  wire logic [lsf_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [lsf_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [lsf_pkg::DATA_W-1:0]  reg_rdata,
  output logic      [4*lsf_pkg::BUS_W-1:0] chan_a_data,
  output logic      [2*lsf_pkg::BUS_W-1:0] chan_b_data,
  output logic                             sample_valid,
  output logic                             aligned
);
  import lsf_pkg::*;

  typedef struct packed {
    logic [NUM_BUS-1:0][1:0]       clk_sync;
    logic [NUM_BUS-1:0]            clk_last;
    logic [NUM_BUS-1:0][BUS_W:0]   in_s0;
    logic [NUM_BUS-1:0][BUS_W:0]   in_s1;
    logic [1:0]                    sync_s;
    logic [1:0]                    bus_mode;
    logic                          dce;
    logic                          lsb_sel;
    logic [3:0]                    resolution;
    logic [NUM_BUS-1:0]            bus_ena;
    logic [PTR_W-1:0]              read_delay;
    logic [NUM_BUS-1:0][PTR_W-1:0] wr_ptr;
    logic [NUM_BUS-1:0]            wr_en;
    logic [NUM_BUS-1:0][PTR_W-1:0] wr_addr;
    logic [NUM_BUS-1:0][BUS_W-1:0] wr_data;
    logic [NUM_BUS-1:0]            seen;
    lsf_phase_t                    phase;
    logic [PTR_W-1:0]              rd_ptr;
    logic [7:0]                    tick_cnt;
    logic                          rd_pend;
    logic [NUM_BUS-1:0][PTR_W-1:0] est;
    logic [DATA_W-1:0]             rdata;
    logic [4*BUS_W-1:0]            chan_a;
    logic [2*BUS_W-1:0]            chan_b;
    logic                          valid;
  } lsf_state_t;

  localparam logic [7:0] TICK_LAST = 8'(READ_TICK - 1);

  lsf_state_t s_ff;
  lsf_state_t nxt_s;

  logic [NUM_BUS-1:0]            raw_clk;
  logic [NUM_BUS-1:0][BUS_W-1:0] raw_dat;
  logic [NUM_BUS-1:0]            raw_str;
  logic [NUM_BUS-1:0][BUS_W-1:0] ram_q;
  logic                          rd_go;

  // comb temporaries
  logic [PTR_W-1:0]   mask;
  logic [NUM_BUS-1:0] mode_ena;
  logic [NUM_BUS-1:0] ena;
  logic               lsb_strobe;
  logic [3:0]         line_idx;
  logic [1:0]         ref_bus;
  logic               ref_align;
  logic               edge_seen;
  logic               rise_seen;
  logic               strobe_hit;
  logic [NUM_BUS-1:0] hit_vec;
  logic [BUS_W-1:0]   smp;
  logic               str;
  logic               tick;
  logic               cfg_write;

  assign raw_clk = {bus_d_clock, bus_c_clock, bus_b_clock, bus_a_clock};
  assign raw_dat = {bus_d_data, bus_c_data, bus_b_data, bus_a_data};
  assign raw_str = {bus_d_strobe, bus_c_strobe, bus_b_strobe, bus_a_strobe};

  // one store per bus, written from the bus side, read on the tick
  genvar g;
  generate
    for (g = 0; g < NUM_BUS; g++) begin : g_ram
      lsf_sample_ram #(
        .WIDTH (BUS_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (PTR_W)
      ) u_ram (
        .clock   (clock),
        .wr_en   (s_ff.wr_en[g]),
        .wr_addr (s_ff.wr_addr[g]),
        .wr_data (s_ff.wr_data[g]),
        .rd_en   (rd_go),
        .rd_addr (s_ff.rd_ptr),
        .rd_data (ram_q[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_s      = s_ff;
    mask       = lsf_range_mask(s_ff.bus_mode, s_ff.dce); // [R22]
    mode_ena   = (s_ff.bus_mode == DUAL_TWO_BUS_MODE) ? 4'h5 : 4'hf; // [R3] [R1] [R4]
    ena        = mode_ena & s_ff.bus_ena;
    lsb_strobe = ~s_ff.sync_s[1] | s_ff.lsb_sel;
    line_idx   = STROBE_LINE_BASE - s_ff.resolution; // [R24] [R12]
    ref_bus    = ena[0] ? 2'h0 : 2'h2; // [R16] [R17]
    ref_align  = 1'b0;
    edge_seen  = 1'b0;
    rise_seen  = 1'b0;
    strobe_hit = 1'b0;
    hit_vec    = '0;
    smp        = '0;
    str        = 1'b0;
    tick       = 1'b0;
    rd_go      = 1'b0;
    cfg_write  = 1'b0;

    // two flops on every bus pin and on sync_n before anything looks at them; the register port is used unflopped
    nxt_s.sync_s = {s_ff.sync_s[0], sync_n};
    for (int b = 0; b < NUM_BUS; b++) begin
      nxt_s.clk_sync[b][0] = raw_clk[b];
      nxt_s.clk_sync[b][1] = s_ff.clk_sync[b][0];
      nxt_s.clk_last[b]    = s_ff.clk_sync[b][1];
      nxt_s.in_s0[b]       = {raw_str[b], raw_dat[b]};
      nxt_s.in_s1[b]       = s_ff.in_s0[b];
    end

    // write side: both link clock edges carry a sample
    for (int b = 0; b < NUM_BUS; b++) begin
      edge_seen = s_ff.clk_sync[b][1] ^ s_ff.clk_last[b];
      rise_seen = s_ff.clk_sync[b][1] & ~s_ff.clk_last[b];
      smp       = s_ff.in_s1[b][BUS_W-1:0];
      str       = s_ff.in_s1[b][BUS_W];
      // line beyond the bus means no data-line strobe
      if (lsb_strobe && (line_idx < 4'(BUS_W))) begin
        str           = str | smp[line_idx]; // [R8] [R14]
        smp[line_idx] = 1'b0; // [R15] [R13]
      end
      // strobe only counts with the rising edge sample
      strobe_hit = rise_seen & str & ena[b]; // [R10]
      hit_vec[b] = strobe_hit;
      nxt_s.wr_en[b]   = edge_seen & ena[b]; // [R18]
      nxt_s.wr_data[b] = smp;
      nxt_s.wr_addr[b] = strobe_hit ? '0 : s_ff.wr_ptr[b]; // [R11]
      if (edge_seen && ena[b]) begin
        nxt_s.wr_ptr[b] = strobe_hit ? 5'h01 : ((s_ff.wr_ptr[b] + 5'h01) & mask); // [R11] [R22]
      end
      if (strobe_hit) begin
        nxt_s.seen[b] = 1'b1;
      end
      if (strobe_hit && (2'(b) == ref_bus)) begin
        ref_align = 1'b1; // [R16]
      end
    end

    // register port; a status read clears the seen flags, a new strobe still wins
    nxt_s.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        OFF_CTRL: begin
          nxt_s.rdata[CTRL_MODE_LSB +: 2] = s_ff.bus_mode;
          nxt_s.rdata[CTRL_DCE_BIT]       = s_ff.dce;
          nxt_s.rdata[CTRL_LSB_BIT]       = s_ff.lsb_sel;
          nxt_s.rdata[CTRL_RES_LSB +: 4]  = s_ff.resolution;
          nxt_s.rdata[CTRL_ENA_LSB +: 4]  = s_ff.bus_ena;
        end
        OFF_DELAY: begin
          nxt_s.rdata[PTR_W-1:0] = s_ff.read_delay;
        end
        OFF_EST: begin
          for (int b = 0; b < NUM_BUS; b++) begin
            nxt_s.rdata[b*EST_STRIDE +: PTR_W] = s_ff.est[b]; // [R19]
          end
        end
        OFF_STATUS: begin
          nxt_s.rdata[PTR_W-1:0]              = s_ff.rd_ptr;
          nxt_s.rdata[STAT_RUN_BIT]           = (s_ff.phase == PH_RUN);
          nxt_s.rdata[STAT_SEEN_LSB +: 4]     = s_ff.seen;
          // clear on read, but a strobe landing now keeps its flag
          nxt_s.seen = hit_vec; // [R11]
        end
        default: begin
          nxt_s.rdata = '0;
        end
      endcase
    end
    if (reg_write) begin
      case (reg_addr)
        OFF_CTRL: begin
          nxt_s.bus_mode   = reg_wdata[CTRL_MODE_LSB +: 2]; // [R23]
          nxt_s.dce        = reg_wdata[CTRL_DCE_BIT];
          nxt_s.lsb_sel    = reg_wdata[CTRL_LSB_BIT];
          nxt_s.resolution = reg_wdata[CTRL_RES_LSB +: 4];
          nxt_s.bus_ena    = reg_wdata[CTRL_ENA_LSB +: 4];
          cfg_write        = 1'b1;
        end
        OFF_DELAY: begin
          nxt_s.read_delay = reg_wdata[PTR_W-1:0]; // [R16] [R21]
          cfg_write        = 1'b1;
        end
        default: begin
          cfg_write = 1'b0;
        end
      endcase
    end

    // read side, converter clock; free-running sample tick
    tick           = (s_ff.tick_cnt == TICK_LAST);
    nxt_s.tick_cnt = tick ? '0 : s_ff.tick_cnt + 8'h01;
    case (s_ff.phase)
      PH_WAIT: begin
        if (ref_align) begin
          // read trails the freshly reset write pointer by the delay
          nxt_s.rd_ptr   = (5'h00 - s_ff.read_delay) & mask; // [R25] [R5]
          nxt_s.tick_cnt = '0;
          nxt_s.phase    = PH_RUN;
        end
      end
      PH_RUN: begin
        if (ref_align) begin
          nxt_s.rd_ptr   = (5'h00 - s_ff.read_delay) & mask; // [R25]
          nxt_s.tick_cnt = '0;
        end else if (tick) begin
          rd_go        = 1'b1; // [R18]
          nxt_s.rd_ptr = (s_ff.rd_ptr + 5'h01) & mask; // [R22] [R25]
        end
      end
      default: begin
        nxt_s.phase = PH_WAIT;
      end
    endcase
    // a new mode or delay needs a fresh alignment
    if (cfg_write) begin
      nxt_s.phase = PH_WAIT;
    end

    // estimate: delay that would read each slot as it lands
    if (rd_go) begin
      for (int b = 0; b < NUM_BUS; b++) begin
        nxt_s.est[b] = (s_ff.read_delay - (s_ff.wr_ptr[b] - s_ff.rd_ptr) + 5'h01) & mask; // [R19] [R20]
      end
    end

    // channel mapping, earliest sample in the low lane
    nxt_s.rd_pend = rd_go;
    nxt_s.valid   = s_ff.rd_pend;
    if (s_ff.rd_pend) begin
      case (s_ff.bus_mode)
        DUAL_FOUR_BUS_MODE: begin
          nxt_s.chan_a = {24'h000000, ram_q[1], ram_q[0]}; // [R1] [R2] [R6]
          nxt_s.chan_b = {ram_q[3], ram_q[2]}; // [R2]
        end
        DUAL_TWO_BUS_MODE: begin
          nxt_s.chan_a = {36'h000000000, ram_q[0]}; // [R3]
          nxt_s.chan_b = {12'h000, ram_q[2]}; // [R3]
        end
        SINGLE_FOUR_BUS_MODE: begin
          nxt_s.chan_a = {ram_q[3], ram_q[2], ram_q[1], ram_q[0]}; // [R4] [R7]
          nxt_s.chan_b = '0;
        end
        default: begin
          nxt_s.chan_a = '0;
          nxt_s.chan_b = '0;
        end
      endcase
    end
  end

  // single register of the whole state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_ff            <= '0;
      s_ff.sync_s     <= 2'h3;
      s_ff.bus_mode   <= MODE_RST;
      s_ff.resolution <= RES_RST;
      s_ff.bus_ena    <= ENA_RST;
      s_ff.read_delay <= DELAY_RST;
      s_ff.phase      <= PH_WAIT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata    = s_ff.rdata;
  assign chan_a_data  = s_ff.chan_a;
  assign chan_b_data  = s_ff.chan_b;
  assign sample_valid = s_ff.valid;
  assign aligned      = (s_ff.phase == PH_RUN);
endmodule

// ---- lsf_input_fifo_properties.sv ----
// port checks for the sample input fifo
`timescale 1ns/1ps
module lsf_input_fifo_properties #(
  parameter int READ_TICK = lsf_pkg::READ_TICK_CYCLES
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        sync_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [47:0] chan_a_data,
  input wire logic [23:0] chan_b_data,
  input wire logic        sample_valid,
  input wire logic        aligned
);
  import lsf_pkg::*;
  logic [11:0] ctrl_ff;
  logic [5:0]  gap_ff;
  logic [4:0]  mask;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadow of the control word, the wrap range depends on it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff <= 12'hfc1;
    end else if (reg_write && reg_addr == OFF_CTRL) begin
      ctrl_ff <= reg_wdata[11:0];
    end
  end
  // cycles since the last sample while running, saturating
  always_ff @(posedge clock) begin
    if (!rst_n || !aligned) begin
      gap_ff <= 6'h00;
    end else if (sample_valid) begin
      gap_ff <= 6'h01;
    end else if (gap_ff != 6'h00 && gap_ff != 6'h3f) begin
      gap_ff <= gap_ff + 6'h01;
    end
  end
  // wrap range worked out independently of the design
  always_comb begin
    if (ctrl_ff[1:0] == 2'h0 && !ctrl_ff[2]) begin
      mask = 5'h07;
    end else if (ctrl_ff[1:0] == 2'h0 || (ctrl_ff[1:0] == 2'h1 && !ctrl_ff[2])) begin
      mask = 5'h0f;
    end else begin
      mask = 5'h1f;
    end
  end
  sequence est_back;
    $past(reg_read) && $past(reg_addr) == OFF_EST && $past(aligned);
  endsequence
  sequence stat_back;
    $past(reg_read) && $past(reg_addr) == OFF_STATUS && $past(aligned);
  endsequence
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  est_range_a: assert property (est_back |-> (reg_rdata & ~{4{3'h0, mask}}) == 32'h0)
    else $error("estimate outside wrap range");
  ptr_range_a: assert property (stat_back |-> (reg_rdata[4:0] & ~mask) == 5'h0)
    else $error("read pointer outside wrap range");
  valid_gap_a: assert property (sample_valid |=> !sample_valid [*8])
    else $error("samples too close");
  valid_pace_a: assert property (gap_ff == READ_TICK && aligned |-> sample_valid)
    else $error("sample missing at read tick");
  idle_quiet_a: assert property (!aligned [*4] |-> !sample_valid)
    else $error("sample while not aligned");
  cfg_drop_a: assert property (reg_write && (reg_addr == OFF_CTRL || reg_addr == OFF_DELAY)
    |=> !aligned)
    else $error("aligned kept after setup write");
  hold_data_a: assert property (!sample_valid |-> $stable(chan_a_data) && $stable(chan_b_data))
    else $error("channel data moved without a sample");
  strobe_zero_a: assert property (sample_valid && (!sync_n || ctrl_ff[3]) && ctrl_ff[7:4] == 4'hc
    |-> !chan_a_data[0] && !chan_a_data[12] && !chan_a_data[24] && !chan_a_data[36]
    && !chan_b_data[0] && !chan_b_data[12])
    else $error("strobe line reached datapath");
endmodule

bind lsf_input_fifo lsf_input_fifo_properties #(.READ_TICK(READ_TICK)) u_props (
  .clock(clock), .rst_n(rst_n), .sync_n(sync_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .chan_a_data(chan_a_data), .chan_b_data(chan_b_data),
  .sample_valid(sample_valid), .aligned(aligned)
);

// ---- lsf_input_fifo_tb.sv ----
// self-checking bench for the sample input fifo
`timescale 1ns/1ps
module lsf_input_fifo_tb;
  import lsf_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        sync_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [47:0] chan_a_data;
  logic [23:0] chan_b_data;
  logic        sample_valid;
  logic        aligned;
  logic        run = 1'b0;
  logic        lsb = 1'b0;
  logic [3:0]  smask = 4'hf;
  logic [3:0]  lclk;
  logic [47:0] ldata;
  logic [3:0]  lstb;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #2 clock = ~clock;
  lsf_input_fifo DUT (
    .clock(clock), .rst_n(rst_n), .bus_a_clock(lclk[0]), .bus_b_clock(lclk[1]),
    .bus_c_clock(lclk[2]), .bus_d_clock(lclk[3]), .bus_a_data(ldata[11:0]),
    .bus_b_data(ldata[23:12]), .bus_c_data(ldata[35:24]), .bus_d_data(ldata[47:36]),
    .bus_a_strobe(lstb[0]), .bus_b_strobe(lstb[1]), .bus_c_strobe(lstb[2]),
    .bus_d_strobe(lstb[3]), .sync_n(sync_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .chan_a_data(chan_a_data), .chan_b_data(chan_b_data), .sample_valid(sample_valid),
    .aligned(aligned));
  lsf_link_model u_link (.run(run), .lsb_strobe(lsb), .strobe_mask(smask),
    .bus_clock(lclk), .bus_data(ldata), .bus_strobe(lstb));
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [47:0] lanes(input logic [8:0] ix);
    return {2'h3, ix, 1'b0, 2'h2, ix, 1'b0, 2'h1, ix, 1'b0, 2'h0, ix, 1'b0};
  endfunction
  // one frame: configure, start the link, check lock, lanes, estimates, strobe flags
  task automatic frame(input logic [11:0] ctrl, input logic sync, input logic lsel,
                       input logic [3:0] sm, input logic lock, input logic data_ok);
    logic [3:0]  ena;
    logic [4:0]  m;
    logic [47:0] wm;
    logic [8:0]  ix;
    logic [31:0] d;
    logic [4:0]  dif;
    int          k;
    ena = (ctrl[1:0] == 2'h0) ? (ctrl[11:8] & 4'h5) : ctrl[11:8];
    m = (ctrl[1:0] == 2'h0 && !ctrl[2]) ? 5'h07 :
        (ctrl[1:0] == 2'h0 || (ctrl[1:0] == 2'h1 && !ctrl[2])) ? 5'h0f : 5'h1f;
    wm = (ctrl[1:0] == 2'h0) ? 48'hfff : (ctrl[1:0] == 2'h1) ? 48'hff_ffff : {48{1'b1}};
    @(posedge clock);
    sync_n <= sync;
    lsb <= lsel;
    smask <= sm;
    wr(OFF_CTRL, {20'h0, ctrl});
    wr(OFF_DELAY, 32'h4);
    run <= 1'b1;
    k = 0;
    while (aligned !== 1'b1 && k < 300) begin
      @(posedge clock);
      k++;
    end
    chk_flag(aligned, lock, "lock");
    if (aligned === 1'b1 && data_ok) begin
      for (int p = 0; p < 40; p++) begin
        k = 0;
        do begin
          @(posedge clock);
          #1;
          k++;
        end while (sample_valid !== 1'b1 && k < 30);
        if (p == 20) ix = chan_a_data[9:1];
        if (p >= 20) begin
          chk_val(chan_a_data & wm, lanes(ix) & wm, "chan a");
          if (ctrl[1:0] != 2'h2) chk_val({24'h0, chan_b_data} & wm, (lanes(ix) >> 24) & wm, "chan b");
          if (ctrl[1:0] == 2'h2) chk_val({24'h0, chan_b_data}, 48'h0, "chan b idle");
          ix++;
        end
      end
      rd(OFF_EST, d);
      for (int b = 0; b < 4; b++) begin
        dif = (d[8*b +: 5] - d[4:0]) & m;
        if (ena[b]) chk_flag(dif <= 5'h01 || dif == m, 1'b1, "spread");
      end
    end
    run <= 1'b0;
    repeat (60) @(posedge clock);
    rd(OFF_STATUS, d);
    chk_val(d[15:12], sm & ena, "seen");
    rd(OFF_STATUS, d);
    chk_val(d[15:12], 4'h0, "seen cleared");
  endtask
  // hang guard, well above the length of the sequence
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      wrap_up();
    end
  end
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFF_CTRL, d);
    chk_val(d, 32'hfc1, "ctrl reset");
    rd(OFF_DELAY, d);
    chk_val(d, 32'h0, "delay reset");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, d);
    chk_val(d, 32'h0, "unmapped");
    chk_flag(aligned, 1'b0, "idle");
    frame(12'hfc1, 1'b1, 1'b0, 4'hf, 1'b1, 1'b1);
    frame(12'hfc0, 1'b1, 1'b0, 4'hf, 1'b1, 1'b1);
    frame(12'hfc4, 1'b1, 1'b0, 4'hf, 1'b1, 1'b1);
    frame(12'hfc2, 1'b1, 1'b0, 4'hf, 1'b1, 1'b1);
    frame(12'hfc1, 1'b0, 1'b1, 4'hf, 1'b1, 1'b1);
    frame(12'hfc9, 1'b1, 1'b1, 4'hf, 1'b1, 1'b1);
    frame(12'hfc1, 1'b1, 1'b0, 4'h4, 1'b0, 1'b0);
    frame(12'hec1, 1'b1, 1'b0, 4'h4, 1'b1, 1'b0);
    wrap_up();
  end
endmodule

// ---- lsf_link_model.sv ----
// far-end logic device: four ddr sample buses with strobes
`timescale 1ns/1ps
module lsf_link_model (
  input  wire logic        run,
  input  wire logic        lsb_strobe,
  input  wire logic [3:0]  strobe_mask,
  output logic      [3:0]  bus_clock,
  output logic      [47:0] bus_data,
  output logic      [3:0]  bus_strobe
);
  int n = 0;
  // one sample: bus id, sample index, line zero unless it carries the strobe
  task automatic put(input int s, input logic rising);
    for (int k = 0; k < 4; k++) begin
      bus_data[12*k +: 12] = {k[1:0], s[8:0], lsb_strobe && rising && s == 0 && strobe_mask[k]};
      bus_strobe[k] = !lsb_strobe && rising && s == 0 && strobe_mask[k];
    end
  endtask
  // clocks of all buses aligned, so no skew; stands still low between frames
  initial begin
    bus_clock = 4'h0;
    bus_data = 48'h0;
    bus_strobe = 4'h0;
    forever begin
      if (!run && !bus_clock[0]) begin
        bus_data = ~bus_data & {4{12'hffe}};
        bus_strobe = 4'h0;
        n = 0;
        #40;
      end else begin
        put(n, !bus_clock[0]);
        #20;
        bus_clock = ~bus_clock;
        #20;
        n++;
      end
    end
  end
endmodule

// ---- lsf_pkg.sv ----
// package: constants and types for the sample input fifo
// How it works
// [R1] four-bus dual mode: two buses per channel
// [R2] buses a,b feed chan a; c,d chan b
// [R3] two-bus dual mode: bus a, bus c
// [R4] single mode: four buses feed channel a
// [R5] pointer gap must absorb inter-bus skew
// [R6] aligned clocks: buses b,d arrive early
// [R7] aligned clocks: fourth bank three cycles early
// [R8] strobe on dedicated pin or data line
// [R9] strobe period multiple of four bus clocks
// [R10] strobe sent with rising bus clock edge
// [R11] strobe resets that bus write pointer
// [R12] strobe data line follows input width
// [R13] sender zeroes line during changeover
// [R14] dedicated strobe low, sync high when selected
// [R15] strobe line reads zero into datapath
// [R16] one delay; align to bus 0, else 2
// [R17] channel b strobes aligned to channel a
// [R18] write on bus clock, read converter clock
// [R19] per-bus readable delay estimate
// [R20] equal phases give estimates within one
// [R21] software picks delay good for all
// [R22] delay wraps 0-31, 0-15 or 0-7
// [R23] mode field 1 four-bus, 0 two-bus, 2 single
// [R24] strobe line index twelve minus resolution
// [R25] read pointer trails aligned write by delay
package lsf_pkg;
  localparam int NUM_BUS   = 4;
  localparam int BUS_W     = 12;
  localparam int PTR_W     = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DELAY  = 8'h04;
  localparam logic [7:0] OFF_EST    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // control, estimate and status field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DCE_BIT  = 2;
  localparam int CTRL_LSB_BIT  = 3;
  localparam int CTRL_RES_LSB  = 4;
  localparam int CTRL_ENA_LSB  = 8;
  localparam int EST_STRIDE    = 8;
  localparam int STAT_RUN_BIT  = 8;
  localparam int STAT_SEEN_LSB = 12;

  // values after reset
  localparam logic [1:0] MODE_RST   = 2'h1;
  localparam logic [3:0] RES_RST    = 4'hc;
  localparam logic [3:0] ENA_RST    = 4'hf;
  localparam logic [4:0] DELAY_RST  = 5'h00;

  // mode encodings and strobe line base
  localparam logic [1:0] DUAL_TWO_BUS_MODE    = 2'h0;
  localparam logic [1:0] DUAL_FOUR_BUS_MODE   = 2'h1;
  localparam logic [1:0] SINGLE_FOUR_BUS_MODE = 2'h2;
  localparam logic [3:0] STROBE_LINE_BASE     = 4'hc;

  localparam logic [4:0] MASK_8  = 5'h07;
  localparam logic [4:0] MASK_16 = 5'h0f;
  localparam logic [4:0] MASK_32 = 5'h1f;

  // read side paced at one sample per bus sample period
  localparam int CLK_PERIOD_NS    = 4;
  localparam int SAMPLE_PERIOD_NS = 40;
  localparam int READ_TICK_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic {
    PH_WAIT,
    PH_RUN
  } lsf_phase_t;

  // pointer wrap for the current mode and double clock
  function automatic logic [4:0] lsf_range_mask(input logic [1:0] mode, input logic dce);
    if ((mode == DUAL_TWO_BUS_MODE) && !dce) begin
      return MASK_8;
    end else if (((mode == DUAL_FOUR_BUS_MODE) && !dce) ||
                 ((mode == DUAL_TWO_BUS_MODE) && dce)) begin
      return MASK_16;
    end else begin
      return MASK_32;
    end
  endfunction
endpackage

// ---- lsf_sample_ram.sv ----
// small per-bus sample store with registered read data
`timescale 1ns/1ps
module lsf_sample_ram #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clock,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic [WIDTH-1:0]      rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            q;
  } lsf_ram_t;

  lsf_ram_t r_ff;
  lsf_ram_t nxt_r;

  // write and read in one pass; contents need no reset
  always_comb begin
    nxt_r = r_ff;
    if (wr_en) begin
      nxt_r.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      nxt_r.q = r_ff.mem[rd_addr];
    end
  end

  always_ff @(posedge clock) begin
    r_ff <= nxt_r;
  end

  assign rd_data = r_ff.q;
endmodule
